// file: hw/lrp_power_ctrl.sv
// Refresh and low-power state control of a low-power DDR memory.
// Assumes commands and CKE are synchronous to clk_i; clk_i also stands in
// for the internal oscillator, so it keeps running in self refresh.

module lrp_power_ctrl
  import lrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command bus from the controller
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  // Device-internal status and settings
  input wire logic [BANKS-1:0] bank_open_i,
  input wire logic [2:0] pasr_i,
  input wire logic temp_hot_i,
  input wire logic init_done_i,
  // Toward the array and pads
  output logic ref_req_o,
  output logic [ROW_W-1:0] ref_row_o,
  output logic buf_en_o,
  output logic array_pwr_o,
  output lrp_state_t pwr_state_o,
  output logic cmd_err_o,
  output logic need_init_o
);

  function automatic logic in_pasr(input logic [ROW_W-1:0] row,
                                   input logic [2:0] sel);
    logic hit;
    hit = 1'b1;
    unique case (sel)
      PASR_HALF: hit = (row[12] == 1'b0);
      PASR_QUARTER: hit = (row[12:11] == 2'h0);
      PASR_EIGHTH: hit = (row[12:10] == 3'h0);
      PASR_SIXTEENTH: hit = (row[12:9] == 4'h0);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  lrp_cmd_t cmd;
  logic quiet;
  lrp_state_t state_r, state_nxt;
  logic [CNT_W-1:0] wait_r, wait_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] ref_row_r;
  logic ref_req_r;
  logic buf_en_r;
  logic array_pwr_r;
  logic cmd_err_r, err_nxt;
  logic need_init_r;
  logic aref_go;
  logic sref_tick;
  logic deep_exit;

  assign cmd = cmd_decode(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  assign quiet = (cmd == CMD_NOP) || (cmd == CMD_DESEL);
  assign sref_tick = (state_r == ST_SREF) && (tmr_r == '0);

  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    err_nxt = 1'b0;
    aref_go = 1'b0;
    deep_exit = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (!cke_i) begin
          if (cmd == CMD_AREF) begin
            state_nxt = ST_SREF;
          end else if (cmd == CMD_DEEP_POWER_DOWN) begin
            state_nxt = ST_DEEP_POWER_DOWN;
          end else if (|bank_open_i) begin
            state_nxt = ST_PDN_ACT;
          end else begin
            state_nxt = ST_PDN_PRE;
          end
        end else if (cmd == CMD_AREF) begin
          // Address pins play no part here
          aref_go = 1'b1;
          state_nxt = ST_AREF;
          wait_nxt = CNT_W'(RFC_CYC - 1);
        end
      end
      ST_AREF: begin
        // Flag a controller that breaks the refresh period
        err_nxt = !quiet || !cke_i;
        if (wait_r == '0) begin
          state_nxt = ST_IDLE;
        end else begin
          wait_nxt = wait_r - 1'b1;
        end
      end
      ST_SREF: begin
        // Only CKE is watched until it rises; the wake cycle must then be quiet
        if (cke_i) begin
          if (quiet) begin
            state_nxt = ST_SREF_EXIT;
            wait_nxt = CNT_W'(XSR_CYC - 1);
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      ST_PDN_PRE, ST_PDN_ACT: begin
        if (cke_i) begin
          if (quiet) begin
            state_nxt = ST_PDN_EXIT;
            wait_nxt = CNT_W'(XP_CYC - 1);
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      ST_SREF_EXIT, ST_PDN_EXIT: begin
        // At least one quiet cycle before any valid command
        err_nxt = !quiet;
        if (wait_r == '0) begin
          state_nxt = ST_IDLE;
        end else begin
          wait_nxt = wait_r - 1'b1;
        end
      end
      ST_DEEP_POWER_DOWN: begin
        if (cke_i) begin
          if (quiet) begin
            state_nxt = ST_IDLE;
            deep_exit = 1'b1;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      wait_r <= '0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Cool silicon leaks less, so the interval is doubled then
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tmr_r <= TMR_W'(SREF_INT_CYC - 1);
    end else if (state_r != ST_SREF || tmr_r == '0) begin
      tmr_r <= temp_hot_i ? TMR_W'(SREF_INT_CYC - 1)
                          : TMR_W'(2 * SREF_INT_CYC - 1);
    end else begin
      tmr_r <= tmr_r - 1'b1;
    end
  end

  // Row counter walks the whole array; unselected rows are skipped in self refresh
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      row_r <= '0;
      ref_row_r <= '0;
      ref_req_r <= 1'b0;
    end else begin
      ref_req_r <= aref_go || (sref_tick && in_pasr(row_r, pasr_i));
      if (aref_go || sref_tick) begin
        row_r <= row_r + 1'b1;
        ref_row_r <= row_r;
      end
    end
  end

  // Deep power-down removes array power, so data is gone
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_en_r <= 1'b1;
      array_pwr_r <= 1'b1;
    end else begin
      buf_en_r <= !(state_nxt inside {ST_SREF, ST_PDN_PRE, ST_PDN_ACT,
                                      ST_DEEP_POWER_DOWN});
      array_pwr_r <= (state_nxt != ST_DEEP_POWER_DOWN);
    end
  end

  // Set wins over the clear from the init sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      need_init_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end else begin
      cmd_err_r <= err_nxt;
      if (deep_exit) begin
        need_init_r <= 1'b1;
      end else if (init_done_i) begin
        need_init_r <= 1'b0;
      end
    end
  end

  assign ref_req_o = ref_req_r;
  assign ref_row_o = ref_row_r;
  assign buf_en_o = buf_en_r;
  assign array_pwr_o = array_pwr_r;
  assign pwr_state_o = state_r;
  assign cmd_err_o = cmd_err_r;
  assign need_init_o = need_init_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence aref_cmd_s;
    state_r == ST_IDLE && cke_i && cmd == CMD_AREF;
  endsequence

  aref_row_a: assert property (
    aref_cmd_s |=> ref_req_o && ref_row_o == $past(row_r)
      && row_r == $past(row_r) + 1'b1)
    else $error("auto refresh row not from counter");

  aref_len_a: assert property (
    aref_cmd_s |=> (state_r == ST_AREF) [*8] ##1 state_r == ST_IDLE)
    else $error("auto refresh period length wrong");

  sref_entry_a: assert property (
    state_r == ST_IDLE && !cke_i && cmd == CMD_AREF
      |=> state_r == ST_SREF)
    else $error("self refresh not entered");

  sref_hold_a: assert property (
    state_r == ST_SREF && !cke_i |=> state_r == ST_SREF)
    else $error("self refresh left with CKE low");

  // Cycles since the last self refresh tick; a counter, as the span is long
  logic [TMR_W-1:0] sref_age_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_r != ST_SREF || sref_tick) begin
      sref_age_r <= '0;
    end else begin
      sref_age_r <= sref_age_r + 1'b1;
    end
  end

  sref_tick_a: assert property (
    state_r == ST_SREF |-> sref_age_r < TMR_W'(2 * SREF_INT_CYC))
    else $error("self refresh timer stalled");

  pasr_row_a: assert property (
    $past(sref_tick) && ref_req_o
      |-> in_pasr(ref_row_o, $past(pasr_i)))
    else $error("row outside retained portion refreshed");

  pdn_kind_a: assert property (
    state_r == ST_IDLE && !cke_i && cmd != CMD_AREF
      && cmd != CMD_DEEP_POWER_DOWN
      |=> state_r == ($past(|bank_open_i) ? ST_PDN_ACT : ST_PDN_PRE))
    else $error("wrong power-down kind");

  buf_off_a: assert property (
    state_r inside {ST_PDN_PRE, ST_PDN_ACT, ST_SREF} |-> !buf_en_o)
    else $error("buffers on in low power");

  sequence pdn_wake_s;
    state_r inside {ST_PDN_PRE, ST_PDN_ACT} && cke_i && quiet;
  endsequence

  pdn_exit_a: assert property (
    pdn_wake_s |=> state_r == ST_PDN_EXIT ##1 state_r == ST_IDLE
      && buf_en_o)
    else $error("power-down exit timing wrong");

  deep_entry_a: assert property (
    state_r == ST_IDLE && !cke_i && !cs_n_i && !we_n_i && ras_n_i
      && cas_n_i |=> state_r == ST_DEEP_POWER_DOWN && !array_pwr_o)
    else $error("deep power-down not entered");

  deep_exit_a: assert property (
    state_r == ST_DEEP_POWER_DOWN && cke_i && quiet
      |=> need_init_o && array_pwr_o && state_r == ST_IDLE)
    else $error("deep power-down exit lost init demand");

  exit_quiet_a: assert property (
    state_r inside {ST_SREF_EXIT, ST_PDN_EXIT} && !quiet |=> cmd_err_o)
    else $error("command during exit not flagged");

endmodule

// file: inc/lrp_pkg.sv
// Constants, commands and states of the refresh and power-mode block.
// Assumes a 100 MHz core clock that keeps running in low-power states.
package lrp_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Device timings in ns (plain defaults)
  localparam int unsigned T_RFC_NS = 72;
  localparam int unsigned T_XSR_NS = 112;
  localparam int unsigned T_XP_NS = 10;
  localparam int unsigned T_SREF_INT_NS = 7800;

  // Least times round up to whole cycles, never below one
  localparam int unsigned RFC_RAW = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned XSR_RAW = (T_XSR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned XP_RAW = (T_XP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RFC_CYC = (RFC_RAW < 1) ? 1 : RFC_RAW;
  // Self refresh exit spans at least two clock pulses
  localparam int unsigned XSR_CYC = (XSR_RAW < 2) ? 2 : XSR_RAW;
  localparam int unsigned XP_CYC = (XP_RAW < 1) ? 1 : XP_RAW;
  // Longest interval rounds down
  localparam int unsigned SREF_INT_CYC = T_SREF_INT_NS * CLK_MHZ / 1000;

  localparam int unsigned ROW_W = 13;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned TMR_W = 12;
  localparam int unsigned BANKS = 4;

  // Partial-array selections of the extended mode register
  localparam logic [2:0] PASR_FULL = 3'h0;
  localparam logic [2:0] PASR_HALF = 3'h1;
  localparam logic [2:0] PASR_QUARTER = 3'h2;
  localparam logic [2:0] PASR_EIGHTH = 3'h5;
  localparam logic [2:0] PASR_SIXTEENTH = 3'h6;

  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_AREF, CMD_DEEP_POWER_DOWN, CMD_OTHER
  } lrp_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_AREF, ST_SREF, ST_SREF_EXIT,
    ST_PDN_PRE, ST_PDN_ACT, ST_PDN_EXIT, ST_DEEP_POWER_DOWN
  } lrp_state_t;

  function automatic lrp_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    lrp_cmd_t c;
    c = CMD_OTHER;
    if (cs_n) begin
      c = CMD_DESEL;
    end else if ({ras_n, cas_n, we_n} == 3'h7) begin
      c = CMD_NOP;
    end else if ({ras_n, cas_n, we_n} == 3'h1) begin
      c = CMD_AREF;
    end else if ({ras_n, cas_n, we_n} == 3'h6) begin
      c = CMD_DEEP_POWER_DOWN;
    end
    return c;
  endfunction

endpackage

// file: sim/lrp_ctrl_model.sv
// Controller model that drives the command pins of the power-mode block.
// Assumes the bench calls cmd from one process, one command per cycle.
module lrp_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Command pins
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_r = 1'b0;

  initial begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
  end

  // Codes: 0 nop, 1 deselect, 2 refresh, 3 deep power-down, 4 activate
  task automatic cmd(input logic cke, input int c, input int n = 1);
    repeat (n) begin
      @(negedge clk_i);
      cke_o = cke;
      flip_r = ~flip_r;
      case (c)
        // Deselected pins toggle so stale values never look valid
        1: {cs_n_o, ras_n_o, cas_n_o, we_n_o} = {1'b1, {3{flip_r}}};
        2: {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h1;
        3: {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h6;
        4: {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h3;
        default: {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
      endcase
    end
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the refresh and power-mode block.
// Assumes the controller model drives commands at falling edges.
module tb_top import lrp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_n_i = 1'b0, temp_hot_i = 1'b1, init_done_i = 1'b0;
  logic [BANKS-1:0] bank_open_i = '0;
  logic [2:0] pasr_i = PASR_FULL;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic ref_req_o, buf_en_o, array_pwr_o, cmd_err_o, need_init_o;
  logic [ROW_W-1:0] ref_row_o;
  lrp_state_t pwr_state_o;
  logic [15:0] exp_q[$];
  int errors = 0, num_checks = 0;
  int waited = 0;
  logic [31:0] seed = 32'hf58e;

  // Frequency fixed and never stopped, so every timing stays met
  always #5 clk_i = ~clk_i;

  lrp_ctrl_model m (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n));

  lrp_power_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .bank_open_i(bank_open_i), .pasr_i(pasr_i), .temp_hot_i(temp_hot_i),
    .init_done_i(init_done_i), .ref_req_o(ref_req_o),
    .ref_row_o(ref_row_o), .buf_en_o(buf_en_o), .array_pwr_o(array_pwr_o),
    .pwr_state_o(pwr_state_o), .cmd_err_o(cmd_err_o),
    .need_init_o(need_init_o));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Refresh pulse stands one cycle, so it is sampled mid-cycle
  always @(negedge clk_i) begin
    if (ref_req_o !== 1'b0) begin
      if (exp_q.size() == 0) begin
        check(16'hffff, {3'h0, ref_row_o});
      end else begin
        check(exp_q.pop_front(), {3'h0, ref_row_o});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    // Back-to-back refreshes, exact busy length, refused command
    bank_open_i = '0;
    exp_q.push_back(16'h0);
    m.cmd(1'b1, 2);
    m.cmd(1'b1, 0, 8);
    check(ST_AREF, pwr_state_o);
    exp_q.push_back(16'h1);
    m.cmd(1'b1, 2);
    check(ST_IDLE, pwr_state_o);
    m.cmd(1'b1, 0, 2);
    m.cmd(1'b1, 4);
    m.cmd(1'b1, 0);
    check(1'b1, cmd_err_o);
    m.cmd(1'b1, 0, 8);
    $display("auto refresh done");
    // Precharge then active power-down, with a refused wake
    for (int i = 0; i < 2; i++) begin
      bank_open_i = (i == 0) ? '0 : BANKS'(xs() | 32'h1);
      m.cmd(1'b0, 0);
      m.cmd(1'b0, 4);
      check(i ? ST_PDN_ACT : ST_PDN_PRE, pwr_state_o);
      check(1'b0, buf_en_o);
      m.cmd(1'b0, 1, 1 + (xs() % 20));
      m.cmd(1'b1, 4);
      m.cmd(1'b0, 0);
      check(1'b1, cmd_err_o);
      check(i ? ST_PDN_ACT : ST_PDN_PRE, pwr_state_o);
      m.cmd(1'b1, 0);
      // Second pass puts a command inside the exit time
      m.cmd(1'b1, i ? 4 : 0);
      check(ST_PDN_EXIT, pwr_state_o);
      check(1'b1, buf_en_o);
      m.cmd(1'b1, 1);
      check(ST_IDLE, pwr_state_o);
      check(i[0], cmd_err_o);
    end
    $display("power-down done");
    // Self refresh continues the auto refresh row count, hot then cool; commands ignored
    bank_open_i = '0;
    for (int t = 0; t < 2; t++) begin
      temp_hot_i = (t == 0);
      // Low rows lie in every partial selection, so each tick refreshes
      pasr_i = 3'(xs());
      exp_q.push_back(16'(2 + t));
      m.cmd(1'b0, 2);
      m.cmd(1'b0, 4);
      check(ST_SREF, pwr_state_o);
      waited = 0;
      while (waited < 1700 && exp_q.size() != 0) begin
        m.cmd(1'b0, 1);
        waited++;
      end
      check(16'h0, 16'(exp_q.size()));
      check(1'b1, waited >= (t + 1) * SREF_INT_CYC);
      check(1'b1, waited <= (t + 1) * SREF_INT_CYC + 1);
      m.cmd(1'b1, 0);
      m.cmd(1'b1, 0, 12);
      check(ST_SREF_EXIT, pwr_state_o);
      m.cmd(1'b1, 1);
      check(ST_IDLE, pwr_state_o);
    end
    $display("self refresh done");
    // Deep power-down drops the array and demands a new init
    m.cmd(1'b0, 3);
    m.cmd(1'b0, 0);
    check(ST_DEEP_POWER_DOWN, pwr_state_o);
    check(1'b0, array_pwr_o);
    m.cmd(1'b1, 0);
    m.cmd(1'b1, 0);
    check({ST_IDLE, 2'h3}, {pwr_state_o, need_init_o, array_pwr_o});
    // No shared data bus here, so nothing drives it after exit
    init_done_i = 1'b1;
    @(negedge clk_i);
    init_done_i = 1'b0;
    @(negedge clk_i);
    check(1'b0, need_init_o);
    $display("deep power-down done");
    report_and_stop();
  end
endmodule
